// ---- mie_cfg.svh ----
// Constants for the instruction execution unit
// Behaviour
// - Taken skip costs two cycles, else one
// - Writing program counter low byte costs two
// - Alternating pre-clear pair clears timeout, powerdown flags
// - Repeating one pre-clear instruction does nothing
// - Add with carry updates overflow, zero, halves
// - Plain add ignores carry, updates four flags
// - AND changes only zero flag
// - OR changes only zero flag
// - Call pushes next address, two cycles
// - Clear byte or bit, no flags
// - Watchdog clear resets counter and both flags
// - Complement inverts operand, zero flag only
// - Decimal adjust adds six nibbles, carry only
// - Increment or decrement, zero flag only
// - Halt stops, clears watchdog, sets powerdown
// - Jump loads target with one dummy cycle
// - Moves change no flag
// - Return pops program counter, optional load
// - Interrupt return enables, pending interrupt first
// - Rotate left writes memory, no flags
// - Register rotate leaves memory unchanged
`ifndef MIE_CFG_SVH
`define MIE_CFG_SVH
`define MIE_ADR_WB_CTRL 4'h0
`define MIE_ADR_WB_STAT 4'h1
`define MIE_ADR_WB_PC 4'h2
`define MIE_ADR_WB_ACC 4'h3
`define MIE_ADR_WB_WDT 4'h4
`define MIE_CTRL_RUN 0
`define MIE_CTRL_IRQ 1
`define MIE_IRQ_VECTOR 12'h004
`define MIE_DAA_LOW 8'h06
`define MIE_DAA_HIGH 8'h60
`define MIE_STACK_DEPTH 4
`endif

// ---- mie_pkg.sv ----
// Types for the instruction execution unit
package mie_pkg;
  typedef enum logic [4:0] {
    mie_nop, mie_adc, mie_add_with_carry_to_mem_op, mie_add, mie_add_to_mem_op, mie_addi, mie_and, mie_bitwise_and_to_mem_op, mie_andi,
    mie_or, mie_orm, mie_ori, mie_movam, mie_movma, mie_movai, mie_clr, mie_clrb,
    mie_cpl, mie_complement_to_reg_op, mie_inc, mie_increment_to_reg_op, mie_dec, mie_decrement_to_reg_op, mie_daa, mie_rl, mie_rla,
    mie_jmp, mie_call, mie_ret, mie_interrupt_return_op, mie_retai, mie_wdt
  } mie_op_e;
  typedef enum logic [2:0] {
    mie_wdt_clear, mie_wdt_pre_a, mie_wdt_pre_b, mie_wdt_halt, mie_wdt_skipz, mie_wdt_writepcl
  } mie_misc_e;
  typedef enum logic {mie_st_exec, mie_st_dummy} mie_state_e;
endpackage

// ---- mie_core.sv ----
// Instruction execution unit with a classic Wishbone control port
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "mie_cfg.svh"
module mie_core #(
  parameter int ADDR_W = 12,
  parameter int DMEM_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction stream
  input wire logic [4:0] op_i,
  input wire logic [2:0] misc_i,
  input wire logic [DMEM_W-1:0] mem_addr_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_i,
  input wire logic [ADDR_W-1:0] target_i,
  input wire logic op_valid_i,
  output logic op_ready_o,
  // Data memory
  input wire logic [7:0] mem_rdata_i,
  output logic [DMEM_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  // Status
  output logic [ADDR_W-1:0] pc_o,
  output logic [7:0] acc_o,
  output logic halted_o,
  output logic wdt_clear_o,
  // Wishbone slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  mie_pkg::mie_state_e state;
  logic [ADDR_W-1:0] stack [`MIE_STACK_DEPTH];
  logic [1:0] sp;
  logic [7:0] acc;
  logic c_flag, z_flag, ac_flag, ov_flag;
  logic watchdog_timeout_flag, powerdown_flag, global_irq_enable;
  logic run_en, irq_pending;
  logic [1:0] last_pre;
  logic [7:0] wdt_cnt;
  logic [ADDR_W-1:0] pc;
  logic [8:0] sum;
  logic [1:0] half_ov;
  logic [7:0] res, dres;
  logic wr_acc, wr_mem, upd_arith, upd_z, two_cycle, fire, pre_valid;
  logic [ADDR_W-1:0] next_pc;
  mie_pkg::mie_op_e op;

  // Adder producing carry, half carry and overflow
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    add8 = {h[4], (a[7] == b[7]) && (s[7] != a[7]), s};
  endfunction

  assign op = mie_pkg::mie_op_e'(op_i);
  assign fire = op_valid_i && state == mie_pkg::mie_st_exec && run_en && !powerdown_flag;

  always_comb begin
    logic [7:0] rb;
    rb = mem_rdata_i;
    res = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_arith = 1'b0;
    upd_z = 1'b0;
    two_cycle = 1'b0;
    next_pc = ADDR_W'(pc + 1'b1);
    sum = 9'h000;
    half_ov = 2'b00;
    dres = acc;
    case (op)
      mie_pkg::mie_adc, mie_pkg::mie_add_with_carry_to_mem_op: begin
        {half_ov, sum} = add8(acc, rb, c_flag);
        res = sum[7:0];
        upd_arith = 1'b1;
        wr_acc = op == mie_pkg::mie_adc;
        wr_mem = op == mie_pkg::mie_add_with_carry_to_mem_op;
      end
      mie_pkg::mie_add, mie_pkg::mie_add_to_mem_op, mie_pkg::mie_addi: begin
        {half_ov, sum} = add8(acc, (op == mie_pkg::mie_addi) ? imm_i : rb, 1'b0);
        res = sum[7:0];
        upd_arith = 1'b1;
        wr_acc = op != mie_pkg::mie_add_to_mem_op;
        wr_mem = op == mie_pkg::mie_add_to_mem_op;
      end
      mie_pkg::mie_and, mie_pkg::mie_bitwise_and_to_mem_op, mie_pkg::mie_andi: begin
        res = acc & ((op == mie_pkg::mie_andi) ? imm_i : rb);
        upd_z = 1'b1;
        wr_acc = op != mie_pkg::mie_bitwise_and_to_mem_op;
        wr_mem = op == mie_pkg::mie_bitwise_and_to_mem_op;
      end
      mie_pkg::mie_or, mie_pkg::mie_orm, mie_pkg::mie_ori: begin
        res = acc | ((op == mie_pkg::mie_ori) ? imm_i : rb);
        upd_z = 1'b1;
        wr_acc = op != mie_pkg::mie_orm;
        wr_mem = op == mie_pkg::mie_orm;
      end
      mie_pkg::mie_movam: begin
        res = rb;
        wr_acc = 1'b1;
      end
      mie_pkg::mie_movma: begin
        res = acc;
        wr_mem = 1'b1;
      end
      mie_pkg::mie_movai: begin
        res = imm_i;
        wr_acc = 1'b1;
      end
      mie_pkg::mie_clr: wr_mem = 1'b1;
      mie_pkg::mie_clrb: begin
        res = rb & ~(8'h01 << bit_i);
        wr_mem = 1'b1;
      end
      mie_pkg::mie_cpl, mie_pkg::mie_complement_to_reg_op: begin
        res = ~rb;
        upd_z = 1'b1;
        wr_acc = op == mie_pkg::mie_complement_to_reg_op;
        wr_mem = op == mie_pkg::mie_cpl;
      end
      mie_pkg::mie_inc, mie_pkg::mie_increment_to_reg_op, mie_pkg::mie_dec, mie_pkg::mie_decrement_to_reg_op: begin
        res = (op == mie_pkg::mie_inc || op == mie_pkg::mie_increment_to_reg_op) ? 8'(rb + 8'h01) : 8'(rb - 8'h01);
        upd_z = 1'b1;
        wr_acc = op == mie_pkg::mie_increment_to_reg_op || op == mie_pkg::mie_decrement_to_reg_op;
        wr_mem = op == mie_pkg::mie_inc || op == mie_pkg::mie_dec;
      end
      mie_pkg::mie_daa: begin
        if (acc[3:0] > 4'h9 || ac_flag) begin
          dres = 8'(acc + `MIE_DAA_LOW);
        end
        if (acc[7:4] > 4'h9 || c_flag || (acc[7:4] == 4'h9 && dres[7:4] == 4'ha)) begin
          sum = {1'b0, dres} + {1'b0, `MIE_DAA_HIGH};
        end else begin
          sum = {1'b0, dres};
        end
        res = sum[7:0];
        wr_mem = 1'b1;
      end
      mie_pkg::mie_rl: begin
        res = {rb[6:0], rb[7]};
        wr_mem = 1'b1;
      end
      mie_pkg::mie_rla: begin
        res = {rb[6:0], rb[7]};
        wr_acc = 1'b1;
      end
      mie_pkg::mie_jmp, mie_pkg::mie_call: begin
        next_pc = target_i;
        two_cycle = 1'b1;
      end
      mie_pkg::mie_ret, mie_pkg::mie_retai: begin
        next_pc = stack[sp - 2'd1];
        res = imm_i;
        wr_acc = op == mie_pkg::mie_retai;
        two_cycle = 1'b1;
      end
      mie_pkg::mie_interrupt_return_op: begin
        next_pc = irq_pending ? `MIE_IRQ_VECTOR : stack[sp - 2'd1];
        two_cycle = 1'b1;
      end
      mie_pkg::mie_wdt: begin
        case (mie_pkg::mie_misc_e'(misc_i))
          mie_pkg::mie_wdt_skipz: begin
            if (rb == 8'h00) begin
              next_pc = ADDR_W'(pc + 2'd2);
              two_cycle = 1'b1;
            end
          end
          mie_pkg::mie_wdt_writepcl: begin
            next_pc = {pc[ADDR_W-1:8], acc};
            two_cycle = 1'b1;
          end
          default: two_cycle = 1'b0;
        endcase
      end
      default: two_cycle = 1'b0;
    endcase
  end

  assign pre_valid = op == mie_pkg::mie_wdt && fire;

  // Sequencing, dummy cycle after two-cycle instructions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= mie_pkg::mie_st_exec;
      pc <= '0;
      sp <= 2'd0;
      stack <= '{default: '0};
    end else if (state == mie_pkg::mie_st_dummy) begin
      state <= mie_pkg::mie_st_exec;
    end else if (fire) begin
      pc <= next_pc;
      if (two_cycle) begin
        state <= mie_pkg::mie_st_dummy;
      end
      if (op == mie_pkg::mie_call) begin
        stack[sp] <= ADDR_W'(pc + 1'b1);
        sp <= sp + 2'd1;
      end else if (op == mie_pkg::mie_ret || op == mie_pkg::mie_retai ||
          (op == mie_pkg::mie_interrupt_return_op && !irq_pending)) begin
        sp <= sp - 2'd1;
      end
    end
  end

  // Accumulator and arithmetic flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= 8'h00;
      {c_flag, z_flag, ac_flag, ov_flag} <= 4'h0;
    end else if (fire) begin
      if (wr_acc) begin
        acc <= res;
      end
      if (upd_arith) begin
        {ac_flag, ov_flag, c_flag} <= {half_ov, sum[8]};
      end
      if (upd_arith || upd_z) begin
        z_flag <= res == 8'h00;
      end
      if (op == mie_pkg::mie_daa && sum[8]) begin
        c_flag <= 1'b1;
      end
    end
  end

  // Watchdog flags and pre-clear pairing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      last_pre <= 2'd0;
      wdt_cnt <= 8'h00;
      wdt_clear_o <= 1'b0;
    end else begin
      wdt_clear_o <= 1'b0;
      wdt_cnt <= 8'(wdt_cnt + 8'h01);
      if (pre_valid) begin
        case (mie_pkg::mie_misc_e'(misc_i))
          mie_pkg::mie_wdt_clear: begin
            {watchdog_timeout_flag, powerdown_flag} <= 2'b00;
            wdt_cnt <= 8'h00;
            wdt_clear_o <= 1'b1;
            last_pre <= 2'd0;
          end
          mie_pkg::mie_wdt_pre_a, mie_pkg::mie_wdt_pre_b: begin
            if (last_pre == ((misc_i == mie_pkg::mie_wdt_pre_a) ? 2'd2 : 2'd1)) begin
              {watchdog_timeout_flag, powerdown_flag} <= 2'b00;
              wdt_cnt <= 8'h00;
              wdt_clear_o <= 1'b1;
              last_pre <= 2'd0;
            end else begin
              last_pre <= (misc_i == mie_pkg::mie_wdt_pre_a) ? 2'd1 : 2'd2;
            end
          end
          mie_pkg::mie_wdt_halt: begin
            last_pre <= 2'd0;
            powerdown_flag <= 1'b1;
            watchdog_timeout_flag <= 1'b0;
            wdt_cnt <= 8'h00;
            wdt_clear_o <= 1'b1;
          end
          default: last_pre <= 2'd0;
        endcase
      end else if (fire) begin
        last_pre <= 2'd0;
      end
    end
  end

  // Interrupt enable and Wishbone registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable <= 1'b0;
      run_en <= 1'b0;
      irq_pending <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (fire && op == mie_pkg::mie_interrupt_return_op) begin
        global_irq_enable <= 1'b1;
        if (irq_pending) begin
          global_irq_enable <= 1'b0;
          irq_pending <= 1'b0;
        end
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `MIE_ADR_WB_CTRL) begin
          run_en <= wb_dat_i[`MIE_CTRL_RUN];
          if (wb_dat_i[`MIE_CTRL_IRQ]) begin
            irq_pending <= 1'b1;
          end
        end
        case (wb_adr_i)
          `MIE_ADR_WB_CTRL: wb_dat_o <= {30'h0, irq_pending, run_en};
          `MIE_ADR_WB_STAT: wb_dat_o <= {23'h0, global_irq_enable, powerdown_flag, watchdog_timeout_flag,
            last_pre, ov_flag, ac_flag, z_flag, c_flag};
          `MIE_ADR_WB_PC: wb_dat_o <= 32'(pc);
          `MIE_ADR_WB_ACC: wb_dat_o <= {24'h0, acc};
          `MIE_ADR_WB_WDT: wb_dat_o <= {24'h0, wdt_cnt};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_ready_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= 8'h00;
      mem_we_o <= 1'b0;
      pc_o <= '0;
      acc_o <= 8'h00;
      halted_o <= 1'b0;
    end else begin
      op_ready_o <= state == mie_pkg::mie_st_exec && run_en && !powerdown_flag && !(fire && two_cycle);
      mem_addr_o <= mem_addr_i;
      mem_wdata_o <= res;
      mem_we_o <= fire && wr_mem;
      pc_o <= pc;
      acc_o <= acc;
      halted_o <= powerdown_flag;
    end
  end
endmodule

// ---- mie_core_props.sv ----
// Assertion checker for the instruction execution unit ports
`timescale 1ns/10ps
module mie_core_props #(
  parameter int ADDR_W = 12,
  parameter int DMEM_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction side
  input wire logic [4:0] op_i,
  input wire logic [DMEM_W-1:0] mem_addr_i,
  input wire logic op_valid_i,
  input wire logic [7:0] mem_rdata_i,
  // Results
  input wire logic [DMEM_W-1:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_we_o,
  input wire logic [ADDR_W-1:0] pc_o,
  input wire logic [7:0] acc_o,
  input wire logic halted_o,
  input wire logic wdt_clear_o,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  logic wr_op;
  logic reg_op;
  assign wr_op = op_i inside {mie_pkg::mie_add_with_carry_to_mem_op, mie_pkg::mie_add_to_mem_op, mie_pkg::mie_bitwise_and_to_mem_op, mie_pkg::mie_orm,
    mie_pkg::mie_movma, mie_pkg::mie_clr, mie_pkg::mie_clrb, mie_pkg::mie_cpl, mie_pkg::mie_inc,
    mie_pkg::mie_dec, mie_pkg::mie_daa, mie_pkg::mie_rl};
  assign reg_op = op_i inside {mie_pkg::mie_movai, mie_pkg::mie_addi, mie_pkg::mie_complement_to_reg_op, mie_pkg::mie_increment_to_reg_op,
    mie_pkg::mie_decrement_to_reg_op, mie_pkg::mie_rla, mie_pkg::mie_movam, mie_pkg::mie_jmp};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_write_cause: assert property (mem_we_o |-> $past(op_valid_i && wr_op)) else $error("stray memory write");
  a_write_addr: assert property (mem_we_o |-> mem_addr_o == $past(mem_addr_i)) else $error("write address");
  a_reg_no_write: assert property (op_valid_i && reg_op |=> !mem_we_o) else $error("register variant wrote");
  a_clear_zero: assert property (mem_we_o && $past(op_i == mie_pkg::mie_clr) |-> mem_wdata_o == 8'h00)
    else $error("clear value");
  a_rotate_wrap: assert property (mem_we_o && $past(op_i == mie_pkg::mie_rl) |->
    mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])}) else $error("rotate value");
  a_invert_mem: assert property (mem_we_o && $past(op_i == mie_pkg::mie_cpl) |->
    mem_wdata_o == ~$past(mem_rdata_i)) else $error("complement value");
  a_halt_freeze: assert property (halted_o && $past(halted_o) |->
    $stable(acc_o) && $stable(pc_o) && !mem_we_o && halted_o) else $error("activity while halted");
  a_clear_cause: assert property (wdt_clear_o |-> $past(op_valid_i && op_i == mie_pkg::mie_wdt) ||
    $past(op_valid_i && op_i == mie_pkg::mie_wdt, 2)) else $error("stray watchdog clear");
  a_reset_zero: assert property (disable iff (1'b0) rst_i |=> !halted_o && !mem_we_o && acc_o == 8'h00)
    else $error("reset state");
  cover property (mem_we_o);
  cover property ($rose(halted_o));
  cover property (wdt_clear_o);
endmodule
bind mie_core mie_core_props #(.ADDR_W(ADDR_W), .DMEM_W(DMEM_W)) i_props (.clk_i(clk_i), .rst_i(rst_i),
  .op_i(op_i), .mem_addr_i(mem_addr_i), .op_valid_i(op_valid_i), .mem_rdata_i(mem_rdata_i),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .pc_o(pc_o), .acc_o(acc_o),
  .halted_o(halted_o), .wdt_clear_o(wdt_clear_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// ---- mie_dmem.sv ----
// Data memory model facing the execution unit
`timescale 1ns/10ps
module mie_dmem (
  // Clock
  input wire logic clk_i,
  // Read side
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Write side
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i
);
  logic [7:0] mem [256];
  assign rd_data_o = mem[rd_addr_i];
  always @(posedge clk_i) begin
    if (wr_en_i === 1'b1) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
endmodule

// ---- tb.sv ----
// Self-checking testbench for the instruction execution unit
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic cin;
    mie_pkg::mie_op_e op;
    logic [7:0] imm, mem, acc, eacc, emem;
    logic [3:0] eflg;
  } mie_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] op_i = 5'h00;
  logic [2:0] misc_i = 3'h0;
  logic [7:0] mem_addr_i = 8'h20;
  logic [7:0] imm_i = 8'h00;
  logic [2:0] bit_i = 3'h0;
  logic [11:0] target_i = 12'h000;
  logic op_valid_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic op_ready_o, mem_we_o, halted_o, wdt_clear_o, wb_ack_o;
  logic [7:0] mem_rdata_i, mem_addr_o, mem_wdata_o, acc_o;
  logic [11:0] pc_o;
  logic [31:0] wb_dat_o, rd;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int pulses = 0;
  mie_row_s r;
  // Fields: carry in, op, imm, mem, acc, acc out, mem out, flags {ov,ac,z,c}
  mie_row_s rows [27] = '{
    {1'h1, mie_pkg::mie_adc, 40'h000f70800f, 4'hc},
    {1'h1, mie_pkg::mie_add_with_carry_to_mem_op, 40'h00ff010101, 4'h5},
    {1'h1, mie_pkg::mie_add, 40'h0001010201, 4'h0},
    {1'h0, mie_pkg::mie_add_to_mem_op, 40'h0088888810, 4'hd},
    {1'h0, mie_pkg::mie_addi, 40'h7f55018055, 4'hc},
    {1'h1, mie_pkg::mie_and, 40'h00f03c30f0, 4'h5},
    {1'h0, mie_pkg::mie_bitwise_and_to_mem_op, 40'h003cf0f030, 4'h0},
    {1'h1, mie_pkg::mie_andi, 40'h0f555a0a55, 4'h5},
    {1'h1, mie_pkg::mie_or, 40'h0012213312, 4'h5},
    {1'h0, mie_pkg::mie_orm, 40'h0001808081, 4'h0},
    {1'h1, mie_pkg::mie_ori, 40'h0f55f0ff55, 4'h5},
    {1'h1, mie_pkg::mie_movam, 40'h003e003e3e, 4'h7},
    {1'h0, mie_pkg::mie_movma, 40'h0011999999, 4'h2},
    {1'h1, mie_pkg::mie_movai, 40'h4455004455, 4'h7},
    {1'h1, mie_pkg::mie_clr, 40'h00a5121200, 4'h7},
    {1'h0, mie_pkg::mie_clrb, 40'h05ff1212df, 4'h2},
    {1'h1, mie_pkg::mie_cpl, 40'h000f1212f0, 4'h5},
    {1'h0, mie_pkg::mie_complement_to_reg_op, 40'h005a12a55a, 4'h0},
    {1'h1, mie_pkg::mie_inc, 40'h00ff121200, 4'h7},
    {1'h0, mie_pkg::mie_increment_to_reg_op, 40'h007f12807f, 4'h0},
    {1'h0, mie_pkg::mie_dec, 40'h00001212ff, 4'h0},
    {1'h1, mie_pkg::mie_decrement_to_reg_op, 40'h0001120001, 4'h7},
    {1'h0, mie_pkg::mie_daa, 40'h00553b3b41, 4'h2},
    {1'h1, mie_pkg::mie_daa, 40'h0055000066, 4'h7},
    {1'h0, mie_pkg::mie_daa, 40'h0055a5a505, 4'h3},
    {1'h0, mie_pkg::mie_rl, 40'h0081121203, 4'h2},
    {1'h1, mie_pkg::mie_rla, 40'h0080120180, 4'h7}
  };
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  mie_dmem i_mem (.clk_i(clk_i), .rd_addr_i(mem_addr_i), .rd_data_o(mem_rdata_i), .wr_addr_i(mem_addr_o),
    .wr_data_i(mem_wdata_o), .wr_en_i(mem_we_o));
  mie_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .op_i(op_i), .misc_i(misc_i), .mem_addr_i(mem_addr_i),
    .imm_i(imm_i), .bit_i(bit_i), .target_i(target_i), .op_valid_i(op_valid_i), .op_ready_o(op_ready_o),
    .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
    .pc_o(pc_o), .acc_o(acc_o), .halted_o(halted_o), .wdt_clear_o(wdt_clear_o), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic [3:0] adr, input logic we, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic op(input mie_pkg::mie_op_e o, input logic [2:0] m, input logic [7:0] imm, input logic [11:0] t);
    @(posedge clk_i);
    op_i <= o;
    misc_i <= m;
    imm_i <= imm;
    bit_i <= imm[2:0];
    target_i <= t;
    op_valid_i <= 1'b1;
  endtask
  task automatic idle();
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Op then two back-to-back adds; a two-cycle op swallows the first add
  task automatic pair(input mie_pkg::mie_op_e o, input logic [2:0] m, input logic [11:0] t, input logic [7:0] e);
    op(mie_pkg::mie_movai, 3'h0, 8'h00, 12'h000);
    op(o, m, 8'h00, t);
    op(mie_pkg::mie_addi, 3'h0, 8'h01, 12'h000);
    op(mie_pkg::mie_addi, 3'h0, 8'h02, 12'h000);
    idle();
    chk("cycle acc", 32'(e), 32'(acc_o));
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (wdt_clear_o === 1'b1) begin
      pulses <= pulses + 1;
    end
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(4'h0, 1'b1, 32'h1);
    foreach (rows[i]) begin
      r = rows[i];
      i_mem.mem[8'h20] = r.mem;
      op(mie_pkg::mie_movai, 3'h0, r.cin ? 8'hff : 8'h00, 12'h000);
      op(mie_pkg::mie_addi, 3'h0, {7'h00, r.cin}, 12'h000);
      op(mie_pkg::mie_movai, 3'h0, r.acc, 12'h000);
      op(r.op, 3'h0, r.imm, 12'h000);
      idle();
      wb(4'h1, 1'b0, 32'h0);
      chk("acc", 32'(r.eacc), 32'(acc_o));
      chk("mem", 32'(r.emem), 32'(i_mem.mem[8'h20]));
      chk("flags", 32'(r.eflg), 32'(rd[3:0]));
    end
    $display("table done");
    chk("ready", 32'h1, 32'(op_ready_o));
    pair(mie_pkg::mie_jmp, 3'h0, 12'h100, 8'h02);
    pair(mie_pkg::mie_call, 3'h0, 12'h300, 8'h02);
    chk("pc", 32'h301, 32'(pc_o));
    pair(mie_pkg::mie_ret, 3'h0, 12'h000, 8'h02);
    chk("pc", 32'h104, 32'(pc_o));
    i_mem.mem[8'h20] = 8'h00;
    pair(mie_pkg::mie_wdt, mie_pkg::mie_wdt_skipz, 12'h000, 8'h02);
    i_mem.mem[8'h20] = 8'h05;
    pair(mie_pkg::mie_wdt, mie_pkg::mie_wdt_skipz, 12'h000, 8'h03);
    pair(mie_pkg::mie_nop, 3'h0, 12'h000, 8'h03);
    pair(mie_pkg::mie_wdt, mie_pkg::mie_wdt_writepcl, 12'h000, 8'h02);
    op(mie_pkg::mie_retai, 3'h0, 8'h5a, 12'h000);
    idle();
    chk("acc", 32'h5a, 32'(acc_o));
    wb(4'h0, 1'b1, 32'h3);
    pair(mie_pkg::mie_interrupt_return_op, 3'h0, 12'h000, 8'h02);
    chk("pc", 32'h005, 32'(pc_o));
    pair(mie_pkg::mie_interrupt_return_op, 3'h0, 12'h000, 8'h02);
    wb(4'h1, 1'b0, 32'h0);
    chk("irq enable", 32'h1, 32'(rd[8]));
    $display("timing done");
    op(mie_pkg::mie_wdt, mie_pkg::mie_wdt_pre_a, 8'h00, 12'h000);
    op(mie_pkg::mie_wdt, mie_pkg::mie_wdt_pre_a, 8'h00, 12'h000);
    idle();
    chk("wdt clears", 32'h0, 32'(pulses));
    op(mie_pkg::mie_wdt, mie_pkg::mie_wdt_pre_b, 8'h00, 12'h000);
    idle();
    chk("wdt clears", 32'h1, 32'(pulses));
    op(mie_pkg::mie_wdt, mie_pkg::mie_wdt_clear, 8'h00, 12'h000);
    idle();
    chk("wdt clears", 32'h2, 32'(pulses));
    op(mie_pkg::mie_wdt, mie_pkg::mie_wdt_pre_b, 8'h00, 12'h000);
    op(mie_pkg::mie_nop, 3'h0, 8'h00, 12'h000);
    op(mie_pkg::mie_wdt, mie_pkg::mie_wdt_pre_a, 8'h00, 12'h000);
    idle();
    chk("wdt clears", 32'h2, 32'(pulses));
    wb(4'h7, 1'b1, 32'hffffffff);
    wb(4'h7, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("watchdog done");
    op(mie_pkg::mie_movai, 3'h0, 8'h3c, 12'h000);
    op(mie_pkg::mie_wdt, mie_pkg::mie_wdt_halt, 8'h00, 12'h000);
    idle();
    chk("halted", 32'h1, 32'(halted_o));
    chk("ready", 32'h0, 32'(op_ready_o));
    op(mie_pkg::mie_movai, 3'h0, 8'h77, 12'h000);
    idle();
    chk("acc", 32'h3c, 32'(acc_o));
    wb(4'h1, 1'b0, 32'h0);
    chk("wdt flags", 32'h2, 32'(rd[7:6]));
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("halted", 32'h0, 32'(halted_o));
    chk("acc", 32'h0, 32'(acc_o));
    $display("halt done");
    report_and_stop();
  end
endmodule
